// file: rtl/trap_edge_ctrl.sv
// trap status flags, vector table select and external edge polarity
`timescale 1ns/1ps
`default_nettype none
`include "trap_edge_regs.svh"
module trap_edge_ctrl
    import trap_edge_pkg::*;
#(
    parameter int NUM_EXT = 5
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // trap events from the core, one-cycle pulses
    input wire logic addr_err_trap,
    input wire logic stack_err_trap,
    input wire logic clk_fail_trap,
    // interrupt-disable instruction status from the core
    input wire logic irq_disable_instr_active,
    // external interrupt pins, asynchronous
    input wire logic [NUM_EXT-1:0] ext_irq_pin,
    // outputs
    output logic [NUM_EXT-1:0] ext_irq_req,
    output logic alt_vector_table_select,
    output logic irq
);
    state_t s_r;
    state_t s_nxt;
    logic [15:0] wmask;
    logic [4:0] edge_hit;
    logic [7:0] events;
    logic acc;
    logic done;
    logic trap_wr;
    logic vec_wr;
    logic stat_rd;

    always_comb
    begin
        s_nxt = s_r;
        wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        // two flops before any logic sees the pins
        s_nxt.pin_s1 = ext_irq_pin;
        s_nxt.pin_s2 = s_r.pin_s1;
        s_nxt.pin_d = s_r.pin_s2;
        // polarity 1 falling, 0 rising
        edge_hit = (s_r.vec_ctrl[4:0] & s_r.pin_d & ~s_r.pin_s2)
            | (~s_r.vec_ctrl[4:0] & ~s_r.pin_d & s_r.pin_s2);
        s_nxt.ext_req = edge_hit;
        acc = (avs_read || avs_write) && s_r.bus == BUS_IDLE;
        // write lands on the edge the master sees waitrequest low
        done = (avs_read || avs_write) && s_r.bus == BUS_DONE;
        trap_wr = done && avs_write && avs_address == `OFS_TRAP_CTRL;
        vec_wr = done && avs_write && avs_address == `OFS_VEC_CTRL;
        stat_rd = acc && avs_read && avs_address == `OFS_IRQ_STATUS;
        if (s_r.bus == BUS_DONE)
            s_nxt.bus = BUS_IDLE;
        else if (acc)
            s_nxt.bus = BUS_DONE;
        // writes: only implemented bits stored
        if (trap_wr)
            s_nxt.trap_ctrl = (s_r.trap_ctrl & ~(wmask & `TRAP_CTRL_WMASK))
                | (avs_writedata[15:0] & wmask & `TRAP_CTRL_WMASK);
        if (vec_wr)
            s_nxt.vec_ctrl = (s_r.vec_ctrl & ~(wmask & `VEC_CTRL_WMASK))
                | (avs_writedata[15:0] & wmask & `VEC_CTRL_WMASK);
        if (done && avs_write && avs_address == `OFS_IRQ_MASK
            && avs_byteenable[0])
            s_nxt.irq_mask = avs_writedata[7:0];
        // set wins over the software write
        if (addr_err_trap)
            s_nxt.trap_ctrl[`BIT_ADDR_ERR] = 1'b1;
        if (stack_err_trap)
            s_nxt.trap_ctrl[`BIT_STK_ERR] = 1'b1;
        if (clk_fail_trap)
            s_nxt.trap_ctrl[`BIT_CLK_FAIL] = 1'b1;
        // status mirrors core, not writable
        s_nxt.vec_ctrl[`BIT_IRQ_OFF_ACT] = irq_disable_instr_active;
        // read data latched at accept
        if (acc && avs_read)
        begin
            unique case (avs_address)
                `OFS_TRAP_CTRL: s_nxt.rdata = {16'h0000, s_r.trap_ctrl};
                `OFS_VEC_CTRL: s_nxt.rdata = {16'h0000, s_r.vec_ctrl};
                `OFS_IRQ_STATUS: s_nxt.rdata = {24'h000000, s_r.irq_status};
                `OFS_IRQ_MASK: s_nxt.rdata = {24'h000000, s_r.irq_mask};
                default: s_nxt.rdata = 32'h00000000;
            endcase
        end
        // status bits: [2:0] traps, [7:3] ext edges; read clears
        events = {edge_hit, clk_fail_trap, stack_err_trap, addr_err_trap};
        if (stat_rd)
            s_nxt.irq_status = 8'h00;
        s_nxt.irq_status = s_nxt.irq_status | events;
        s_nxt.irq = |(s_nxt.irq_status & s_nxt.irq_mask);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r <= '0;
            s_r.trap_ctrl <= `RST_TRAP_CTRL;
            s_r.vec_ctrl <= `RST_VEC_CTRL;
            s_r.irq_mask <= `RST_IRQ_MASK;
        end
        else
            s_r <= s_nxt;
    end

    // one wait cycle, answer on the second edge
    assign avs_waitrequest = (avs_read || avs_write) && s_r.bus == BUS_IDLE;
    assign avs_readdata = s_r.rdata;
    assign ext_irq_req = s_r.ext_req;
    // table choice steers the core's vector fetch
    assign alt_vector_table_select = s_r.vec_ctrl[`BIT_ALT_VT];
    assign irq = s_r.irq;

    AST_ADDR_ERR: assert property (@(posedge clk) disable iff (!rst_n)
        addr_err_trap |=> s_r.trap_ctrl[`BIT_ADDR_ERR])
        else $error("address error flag not set");
    AST_STK_ERR: assert property (@(posedge clk) disable iff (!rst_n)
        stack_err_trap |=> s_r.trap_ctrl[`BIT_STK_ERR])
        else $error("stack error flag not set");
    AST_CLK_FAIL: assert property (@(posedge clk) disable iff (!rst_n)
        clk_fail_trap |=> s_r.trap_ctrl[`BIT_CLK_FAIL])
        else $error("clock failure flag not set");
    // a flag may only appear through its trap or a software write
    AST_ADDR_SRC: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(s_r.trap_ctrl[`BIT_ADDR_ERR])
            |-> $past(addr_err_trap) || $past(trap_wr))
        else $error("address error flag set without cause");
    AST_STK_SRC: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(s_r.trap_ctrl[`BIT_STK_ERR])
            |-> $past(stack_err_trap) || $past(trap_wr))
        else $error("stack error flag set without cause");
    AST_CLK_SRC: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(s_r.trap_ctrl[`BIT_CLK_FAIL])
            |-> $past(clk_fail_trap) || $past(trap_wr))
        else $error("clock failure flag set without cause");
    AST_ADDR_CLR: assert property (@(posedge clk) disable iff (!rst_n)
        trap_wr && avs_byteenable[0] && !avs_writedata[`BIT_ADDR_ERR]
            && !addr_err_trap |=> !s_r.trap_ctrl[`BIT_ADDR_ERR])
        else $error("address error flag not cleared");
    AST_ST_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
        addr_err_trap |=> s_r.irq_status[0])
        else $error("address error status not set");
    AST_ST_STK: assert property (@(posedge clk) disable iff (!rst_n)
        stack_err_trap |=> s_r.irq_status[1])
        else $error("stack error status not set");
    AST_ST_CLK: assert property (@(posedge clk) disable iff (!rst_n)
        clk_fail_trap |=> s_r.irq_status[2])
        else $error("clock failure status not set");
    AST_KEEP_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.irq_status[0] && !stat_rd |=> s_r.irq_status[0])
        else $error("address error status lost");
    AST_KEEP_STK: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.irq_status[1] && !stat_rd |=> s_r.irq_status[1])
        else $error("stack error status lost");
    AST_KEEP_CLK: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.irq_status[2] && !stat_rd |=> s_r.irq_status[2])
        else $error("clock failure status lost");
    AST_RD_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        stat_rd && events == 8'h00 |=> s_r.irq_status == 8'h00)
        else $error("status not cleared by read");
    AST_UNIMPL_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.trap_ctrl[0] == 1'b0 && s_r.vec_ctrl[13:5] == 9'h000)
        else $error("unimplemented bit nonzero");
    AST_TRAP_UPPER: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.trap_ctrl[15:4] == 12'h000)
        else $error("trap register upper bits nonzero");
    AST_RDATA_HI: assert property (@(posedge clk) disable iff (!rst_n)
        avs_readdata[31:16] == 16'h0000)
        else $error("read data upper half nonzero");
    AST_RD_TRAP0: assert property (@(posedge clk) disable iff (!rst_n)
        acc && avs_read && avs_address == `OFS_TRAP_CTRL
            |=> avs_readdata[0] == 1'b0)
        else $error("trap register bit 0 read nonzero");
    AST_RD_VEC_GAP: assert property (@(posedge clk) disable iff (!rst_n)
        acc && avs_read && avs_address == `OFS_VEC_CTRL
            |=> avs_readdata[13:5] == 9'h000)
        else $error("vector register gap read nonzero");
    AST_RD_UNMAP: assert property (@(posedge clk) disable iff (!rst_n)
        acc && avs_read && avs_address[1:0] != 2'h0 |=> avs_readdata == 0)
        else $error("unmapped read nonzero");
    // per channel, so that each failure except the pin 0 no-edge check names the pin
    sequence rise0_s;
        !s_r.vec_ctrl[0] && !s_r.pin_d[0] && s_r.pin_s2[0];
    endsequence
    sequence fall0_s;
        s_r.vec_ctrl[0] && s_r.pin_d[0] && !s_r.pin_s2[0];
    endsequence
    AST_EDGE0_HIT: assert property (@(posedge clk) disable iff (!rst_n)
        (rise0_s or fall0_s) |=> ext_irq_req[0])
        else $error("ext edge 0 missed");
    AST_EDGE_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
        ext_irq_req[0] |-> $past(s_r.pin_d[0]) != $past(s_r.pin_s2[0]))
        else $error("ext request without edge");
    sequence rise1_s;
        !s_r.vec_ctrl[1] && !s_r.pin_d[1] && s_r.pin_s2[1];
    endsequence
    sequence fall1_s;
        s_r.vec_ctrl[1] && s_r.pin_d[1] && !s_r.pin_s2[1];
    endsequence
    AST_EDGE1_HIT: assert property (@(posedge clk) disable iff (!rst_n)
        (rise1_s or fall1_s) |=> ext_irq_req[1])
        else $error("ext edge 1 missed");
    AST_EDGE1_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
        ext_irq_req[1] |-> $past(s_r.pin_d[1]) != $past(s_r.pin_s2[1]))
        else $error("ext request 1 without edge");
    sequence rise2_s;
        !s_r.vec_ctrl[2] && !s_r.pin_d[2] && s_r.pin_s2[2];
    endsequence
    sequence fall2_s;
        s_r.vec_ctrl[2] && s_r.pin_d[2] && !s_r.pin_s2[2];
    endsequence
    AST_EDGE2_HIT: assert property (@(posedge clk) disable iff (!rst_n)
        (rise2_s or fall2_s) |=> ext_irq_req[2])
        else $error("ext edge 2 missed");
    AST_EDGE2_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
        ext_irq_req[2] |-> $past(s_r.pin_d[2]) != $past(s_r.pin_s2[2]))
        else $error("ext request 2 without edge");
    sequence rise3_s;
        !s_r.vec_ctrl[3] && !s_r.pin_d[3] && s_r.pin_s2[3];
    endsequence
    sequence fall3_s;
        s_r.vec_ctrl[3] && s_r.pin_d[3] && !s_r.pin_s2[3];
    endsequence
    AST_EDGE3_HIT: assert property (@(posedge clk) disable iff (!rst_n)
        (rise3_s or fall3_s) |=> ext_irq_req[3])
        else $error("ext edge 3 missed");
    AST_EDGE3_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
        ext_irq_req[3] |-> $past(s_r.pin_d[3]) != $past(s_r.pin_s2[3]))
        else $error("ext request 3 without edge");
    sequence rise4_s;
        !s_r.vec_ctrl[4] && !s_r.pin_d[4] && s_r.pin_s2[4];
    endsequence
    sequence fall4_s;
        s_r.vec_ctrl[4] && s_r.pin_d[4] && !s_r.pin_s2[4];
    endsequence
    AST_EDGE4_HIT: assert property (@(posedge clk) disable iff (!rst_n)
        (rise4_s or fall4_s) |=> ext_irq_req[4])
        else $error("ext edge 4 missed");
    AST_EDGE4_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
        ext_irq_req[4] |-> $past(s_r.pin_d[4]) != $past(s_r.pin_s2[4]))
        else $error("ext request 4 without edge");
    AST_ST_EXT0: assert property (@(posedge clk) disable iff (!rst_n)
        edge_hit[0] |=> s_r.irq_status[3])
        else $error("ext 0 status not set");
    AST_ST_EXT1: assert property (@(posedge clk) disable iff (!rst_n)
        edge_hit[1] |=> s_r.irq_status[4])
        else $error("ext 1 status not set");
    AST_ST_EXT2: assert property (@(posedge clk) disable iff (!rst_n)
        edge_hit[2] |=> s_r.irq_status[5])
        else $error("ext 2 status not set");
    AST_ST_EXT3: assert property (@(posedge clk) disable iff (!rst_n)
        edge_hit[3] |=> s_r.irq_status[6])
        else $error("ext 3 status not set");
    AST_ST_EXT4: assert property (@(posedge clk) disable iff (!rst_n)
        edge_hit[4] |=> s_r.irq_status[7])
        else $error("ext 4 status not set");
    AST_POL_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        !vec_wr |=> $stable(s_r.vec_ctrl[4:0]))
        else $error("polarity changed without write");
    AST_ALT_VT: assert property (@(posedge clk) disable iff (!rst_n)
        alt_vector_table_select == s_r.vec_ctrl[`BIT_ALT_VT])
        else $error("vector table select mismatch");
    AST_ALT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        !vec_wr |=> $stable(alt_vector_table_select))
        else $error("table select changed without write");
    AST_IRQ_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        irq_disable_instr_active |=> s_r.vec_ctrl[`BIT_IRQ_OFF_ACT])
        else $error("disable status not mirrored");
    AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
        irq == |(s_r.irq_status & s_r.irq_mask))
        else $error("interrupt level mismatch");
    AST_BUS_ONE_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
        (avs_read && avs_waitrequest) |=> !avs_waitrequest)
        else $error("read answer late");
    AST_WR_ONE_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
        (avs_write && avs_waitrequest) |=> !avs_waitrequest)
        else $error("write answer late");
    AST_WAIT_FIRST: assert property (@(posedge clk) disable iff (!rst_n)
        acc |-> avs_waitrequest)
        else $error("request accepted without wait");
    // software may sample read data late, so it must not drift
    AST_RD_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        !(acc && avs_read) |=> $stable(avs_readdata))
        else $error("read data changed without read");
endmodule // trap_edge_ctrl
`default_nettype wire

// file: rtl/trap_edge_regs.svh
// register offsets, field positions and reset values of the trap/edge block
`ifndef TRAP_EDGE_REGS_SVH
`define TRAP_EDGE_REGS_SVH
`define OFS_TRAP_CTRL 4'h0
`define OFS_VEC_CTRL 4'h4
`define OFS_IRQ_STATUS 4'h8
`define OFS_IRQ_MASK 4'hC
`define BIT_ADDR_ERR 3
`define BIT_STK_ERR 2
`define BIT_CLK_FAIL 1
`define BIT_ALT_VT 15
`define BIT_IRQ_OFF_ACT 14
`define TRAP_CTRL_WMASK 16'h000E
`define VEC_CTRL_WMASK 16'h801F
`define RST_TRAP_CTRL 16'h0000
`define RST_VEC_CTRL 16'h0000
`define RST_IRQ_MASK 8'h00
`endif

// file: rtl/trap_edge_pkg.sv
// types of the trap status and external edge control block
package trap_edge_pkg;
    typedef enum logic {
        BUS_IDLE,
        BUS_DONE
    } bus_state_t;
    typedef struct packed {
        bus_state_t bus;
        logic [15:0] trap_ctrl;
        logic [15:0] vec_ctrl;
        logic [7:0] irq_status;
        logic [7:0] irq_mask;
        logic [31:0] rdata;
        logic [4:0] pin_s1;
        logic [4:0] pin_s2;
        logic [4:0] pin_d;
        logic [4:0] ext_req;
        logic irq;
    } state_t;
endpackage

// file: tb/far_side_model.sv
// far side model: trap pulses from the core
`timescale 1ns/1ps
`default_nettype none
module far_side_model
(
    // clock
    input wire logic clk,
    // trap events, one cycle each
    output logic addr_err_trap,
    output logic stack_err_trap,
    output logic clk_fail_trap
);
    logic [2:0] trap_r;
    assign {addr_err_trap, stack_err_trap, clk_fail_trap} = trap_r;
    initial trap_r = 3'h0;
    // bit 2 address, 1 stack, 0 clock failure
    task pulse(input logic [2:0] t);
        @(posedge clk);
        trap_r <= t;
        @(posedge clk);
        trap_r <= 3'h0;
    endtask
endmodule // far_side_model
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench of the trap status and edge control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic di = 1'b0;
    logic [4:0] pin = 5'h00;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdata, q;
    logic wreq, at, st, ct, alt, irq;
    logic [4:0] req;
    logic [4:0] seen;
    int failures = 0;
    int samples_checked = 0;
    always #2 clk = ~clk;
    far_side_model u_far (.clk(clk), .addr_err_trap(at),
        .stack_err_trap(st), .clk_fail_trap(ct));
    trap_edge_ctrl u_dut (.clk(clk), .rst_n(rst_n), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_byteenable(4'h3), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .addr_err_trap(at), .stack_err_trap(st),
        .clk_fail_trap(ct), .irq_disable_instr_active(di), .ext_irq_pin(pin),
        .ext_irq_req(req), .alt_vector_table_select(alt), .irq(irq));
    task test_done;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e)
        begin
            failures++;
            $display("ERROR %s exp %h got %h", nm, e, s);
        end
    endtask
    // request held until a rising edge sees waitrequest low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk);
            if (wreq === 1'b0)
                break;
        end
        q = rdata;
        if (n == 20)
        begin
            failures++;
            test_done();
        end
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, q, e);
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rchk("trap", 4'h0, 32'h0);
        bus(1'b1, 4'h0, 32'hFFFF);
        rchk("trap_ro", 4'h0, 32'h000E);
        for (int i = 1; i < 4; i++)
        begin
            bus(1'b1, 4'h0, 32'h0);
            u_far.pulse(3'(1 << (i - 1)));
            rchk("trap_flag", 4'h0, 32'(1 << i));
        end
        bus(1'b1, 4'h4, 32'hFFFF);
        di <= 1'b1;
        rchk("vec_ro", 4'h4, 32'hC01F);
        chk("alt", 32'(alt), 32'h1);
        bus(1'b1, 4'h4, 32'h0);
        @(negedge clk);
        chk("alt", 32'(alt), 32'h0);
        // clear after the polarity write so a change there is not judged
        for (int p = 0; p < 2; p++)
        begin
            bus(1'b1, 4'h4, p ? 32'h1F : 32'h0);
            bus(1'b0, 4'h8, 32'h0);
            pin <= 5'h1F;
            seen = 5'h00;
            for (int k = 0; k < 6; k++)
            begin
                @(negedge clk);
                seen = seen | req;
            end
            chk("req_rise", 32'(seen), p ? 32'h0 : 32'h1F);
            rchk("rise", 4'h8, p ? 32'h0 : 32'hF8);
            pin <= 5'h00;
            seen = 5'h00;
            for (int k = 0; k < 6; k++)
            begin
                @(negedge clk);
                seen = seen | req;
            end
            chk("req_fall", 32'(seen), p ? 32'h1F : 32'h0);
            rchk("fall", 4'h8, p ? 32'hF8 : 32'h0);
        end
        u_far.pulse(3'h4);
        repeat (3) @(negedge clk);
        chk("irq_masked", 32'(irq), 32'h0);
        bus(1'b1, 4'hC, 32'h1);
        @(negedge clk);
        chk("irq", 32'(irq), 32'h1);
        rchk("status", 4'h8, 32'h1);
        @(negedge clk);
        chk("irq_clr", 32'(irq), 32'h0);
        rchk("unmapped", 4'h2, 32'h0);
        test_done();
    end
endmodule // testbench
`default_nettype wire
